// ===== ebus_phase_seq.sv
// External bus cycle phase sequencer with Wishbone registers and pad control.
//
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.

module ebus_phase_seq (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        ready_i,
    input  wire logic [15:0] ext_din_i,
    output logic      [15:0] ext_addr_o,
    output logic      [15:0] ext_dout_o,
    output logic             ext_doe_o,
    output logic      [3:0]  cs_n_o,
    output logic             rd_n_o,
    output logic             wr_n_o,
    output logic      [1:0]  drive_sel_o,
    output logic      [1:0]  edge_sel_o,
    output logic             reference_clock_out_en_o,
    output logic             ref_clk_o
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic logic [5:0] stretch(input logic [5:0] n);
        return (n != 6'h00 && n < ebus_pkg::GAP_CYC) ? ebus_pkg::GAP_CYC : n;
    endfunction

    function automatic logic [5:0] phase_len(input ebus_pkg::phase_t p, input logic [15:0] c, input logic win);
        logic [5:0] n;
        n = 6'h00;
        unique case (p)
            ebus_pkg::PH_ADDR: n = 6'h01 + {5'h00, c[ebus_pkg::F_AS_LONG]}
                                 + (win ? {4'h0, c[ebus_pkg::F_AS_EXT+:2]} : 6'h00);
            ebus_pkg::PH_CMD:  n = {4'h0, c[ebus_pkg::F_CMD_DLY+:2]};
            ebus_pkg::PH_WSET: n = {5'h00, c[ebus_pkg::F_WSETUP]};
            ebus_pkg::PH_ACC:  n = 6'h01 + {1'b0, c[ebus_pkg::F_ACCESS+:5]}
                                 + {5'h00, c[ebus_pkg::F_RDY_ASYNC] & c[ebus_pkg::F_RDY_EN]};
            ebus_pkg::PH_HOLD: n = {4'h0, c[ebus_pkg::F_HOLD+:2]};
            default:           n = 6'h00;
        endcase
        return stretch(n);
    endfunction

    // Next phase in fixed order, skipping phases of zero length.
    function automatic ebus_pkg::phase_t after(input ebus_pkg::phase_t p, input logic [15:0] c);
        ebus_pkg::phase_t q;
        q = ebus_pkg::PH_IDLE;
        if (p == ebus_pkg::PH_ADDR && phase_len(ebus_pkg::PH_CMD, c, 1'b0) != 6'h00) begin
            q = ebus_pkg::PH_CMD;
        end else if (p inside {ebus_pkg::PH_ADDR, ebus_pkg::PH_CMD}
                     && phase_len(ebus_pkg::PH_WSET, c, 1'b0) != 6'h00) begin
            q = ebus_pkg::PH_WSET;
        end else if (p inside {ebus_pkg::PH_ADDR, ebus_pkg::PH_CMD, ebus_pkg::PH_WSET}) begin
            q = ebus_pkg::PH_ACC;
        end else if (p == ebus_pkg::PH_ACC && phase_len(ebus_pkg::PH_HOLD, c, 1'b0) != 6'h00) begin
            q = ebus_pkg::PH_HOLD;
        end
        return q;
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    ebus_pkg::phase_t state_r, state_nxt;
    logic [15:0] timing_r [4];
    logic [15:0] timing_nxt [4];
    logic [4:0]  ctrl_r, ctrl_nxt;
    logic [15:0] addr_r, addr_nxt, wdata_r, wdata_nxt, rdata_r, rdata_nxt;
    logic [15:0] cfg_r, cfg_nxt;
    logic [1:0]  cs_r, cs_nxt, last_cs_r, last_cs_nxt;
    logic        cs_valid_r, cs_valid_nxt, we_r, we_nxt, win_r, win_nxt;
    logic        done_r, done_nxt, ack_nxt;
    logic [31:0] dat_nxt;
    logic [15:0] ext_addr_nxt, ext_dout_nxt;
    logic [3:0]  cs_n_nxt;
    logic        ext_doe_nxt, rd_n_nxt, wr_n_nxt;
    logic [1:0]  drive_nxt, edge_nxt;
    logic        rdy_s1_r, rdy_s2_r, rdy_act, acc_end, cyc_end;
    logic        wr_acc, rd_req, start, ld;
    logic [5:0]  ld_len;
    logic [7:0]  adr;

    phase_if tmr ();
    phase_timer u_timer (.clk_i(clk_i), .rst_i(rst_i), .t(tmr));
    assign tmr.load = ld;
    assign tmr.len  = ld_len;

    // Bus decode; a write lands on the edge where the master samples ack.
    assign adr    = {wb_adr_i[7:2], 2'b00};
    assign wr_acc = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    assign rd_req = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
    assign start  = wr_acc && adr == ebus_pkg::OFF_CMD && wb_sel_i[0] && state_r == ebus_pkg::PH_IDLE;

    // ------------------------------------------------------------------
    // Ready input
    // ------------------------------------------------------------------
    // Two-flop synchroniser for asynchronous ready.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdy_s1_r <= 1'b0;
            rdy_s2_r <= 1'b0;
        end else begin
            rdy_s1_r <= ready_i;
            rdy_s2_r <= rdy_s1_r;
        end
    end

    // Pick the synchronous or synchronised path, then apply the polarity.
    assign rdy_act = (cfg_r[ebus_pkg::F_RDY_ASYNC] ? rdy_s2_r : ready_i) ^ cfg_r[ebus_pkg::F_RDY_POL];
    assign acc_end = state_r == ebus_pkg::PH_ACC && tmr.last
                     && (!cfg_r[ebus_pkg::F_RDY_EN] || rdy_act);
    assign cyc_end = state_r != ebus_pkg::PH_IDLE && state_nxt == ebus_pkg::PH_IDLE;

    // ------------------------------------------------------------------
    // Phase sequencer
    // ------------------------------------------------------------------
    // Advance one phase when its timer expires and drive the bus pins.
    always_comb begin
        state_nxt    = state_r;
        cfg_nxt      = cfg_r;
        cs_nxt       = cs_r;
        we_nxt       = we_r;
        win_nxt      = win_r;
        last_cs_nxt  = last_cs_r;
        cs_valid_nxt = cs_valid_r;
        rdata_nxt    = rdata_r;
        ext_addr_nxt = ext_addr_o;
        ext_dout_nxt = ext_dout_o;
        unique case (state_r)
            ebus_pkg::PH_IDLE: begin
                if (start) begin
                    cs_nxt       = wb_dat_i[ebus_pkg::F_CMD_CS+:2];
                    we_nxt       = wb_dat_i[ebus_pkg::F_CMD_WE];
                    cfg_nxt      = timing_r[wb_dat_i[ebus_pkg::F_CMD_CS+:2]];
                    win_nxt      = !cs_valid_r || wb_dat_i[ebus_pkg::F_CMD_CS+:2] != last_cs_r;
                    last_cs_nxt  = wb_dat_i[ebus_pkg::F_CMD_CS+:2];
                    cs_valid_nxt = 1'b1;
                    ext_addr_nxt = addr_r;
                    ext_dout_nxt = wdata_r;
                    state_nxt    = ebus_pkg::PH_ADDR;
                end
            end
            ebus_pkg::PH_ACC: begin
                if (acc_end) begin
                    rdata_nxt = we_r ? rdata_r : ext_din_i;
                    state_nxt = after(state_r, cfg_r);
                end
            end
            ebus_pkg::PH_ADDR, ebus_pkg::PH_CMD, ebus_pkg::PH_WSET, ebus_pkg::PH_HOLD: begin
                if (tmr.last) begin
                    state_nxt = after(state_r, cfg_r);
                end
            end
            default: state_nxt = ebus_pkg::PH_IDLE;
        endcase
        ld     = state_nxt != state_r && state_nxt != ebus_pkg::PH_IDLE;
        ld_len = phase_len(state_nxt, cfg_nxt, win_nxt);
        cs_n_nxt    = (state_nxt == ebus_pkg::PH_IDLE) ? 4'hF : ~(4'h1 << cs_nxt);
        rd_n_nxt    = !(state_nxt == ebus_pkg::PH_ACC && !we_nxt);
        wr_n_nxt    = !(state_nxt == ebus_pkg::PH_ACC && we_nxt);
        ext_doe_nxt = we_nxt && state_nxt inside {ebus_pkg::PH_WSET, ebus_pkg::PH_ACC, ebus_pkg::PH_HOLD};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r    <= ebus_pkg::PH_IDLE;
            cfg_r      <= ebus_pkg::TIMING_RST;
            cs_r       <= 2'h0;
            we_r       <= 1'b0;
            win_r      <= 1'b0;
            last_cs_r  <= 2'h0;
            cs_valid_r <= 1'b0;
            rdata_r    <= 16'h0000;
            ext_addr_o <= 16'h0000;
            ext_dout_o <= 16'h0000;
            ext_doe_o  <= 1'b0;
            cs_n_o     <= 4'hF;
            rd_n_o     <= 1'b1;
            wr_n_o     <= 1'b1;
        end else begin
            state_r    <= state_nxt;
            cfg_r      <= cfg_nxt;
            cs_r       <= cs_nxt;
            we_r       <= we_nxt;
            win_r      <= win_nxt;
            last_cs_r  <= last_cs_nxt;
            cs_valid_r <= cs_valid_nxt;
            rdata_r    <= rdata_nxt;
            ext_addr_o <= ext_addr_nxt;
            ext_dout_o <= ext_dout_nxt;
            ext_doe_o  <= ext_doe_nxt;
            cs_n_o     <= cs_n_nxt;
            rd_n_o     <= rd_n_nxt;
            wr_n_o     <= wr_n_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Register file and pad control
    // ------------------------------------------------------------------
    // Wishbone writes, read mux, done flag and pad selection.
    always_comb begin
        timing_nxt = timing_r;
        ctrl_nxt   = ctrl_r;
        addr_nxt   = addr_r;
        wdata_nxt  = wdata_r;
        done_nxt   = done_r;
        ack_nxt    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        dat_nxt    = wb_dat_o;
        if (wr_acc) begin
            if (adr >= ebus_pkg::OFF_TIMING && adr < ebus_pkg::OFF_CTRL) begin
                timing_nxt[adr[3:2]] = merge16(timing_r[adr[3:2]], wb_dat_i, wb_sel_i);
            end else if (adr == ebus_pkg::OFF_CTRL && wb_sel_i[0]) begin
                ctrl_nxt = wb_dat_i[4:0];
            end else if (adr == ebus_pkg::OFF_STATUS && wb_sel_i[0] && wb_dat_i[ebus_pkg::F_DONE]) begin
                done_nxt = 1'b0;
            end else if (adr == ebus_pkg::OFF_ADDR) begin
                addr_nxt = merge16(addr_r, wb_dat_i, wb_sel_i);
            end else if (adr == ebus_pkg::OFF_WDATA) begin
                wdata_nxt = merge16(wdata_r, wb_dat_i, wb_sel_i);
            end
        end
        // A cycle ending in the same cycle as the clear keeps the flag set.
        if (cyc_end) begin
            done_nxt = 1'b1;
        end
        if (rd_req) begin
            if (adr >= ebus_pkg::OFF_TIMING && adr < ebus_pkg::OFF_CTRL) begin
                dat_nxt = {16'h0000, timing_r[adr[3:2]]};
            end else begin
                unique case (adr)
                    ebus_pkg::OFF_CTRL:   dat_nxt = {27'h000_0000, ctrl_r};
                    ebus_pkg::OFF_STATUS: dat_nxt = {26'h000_0000, state_r == ebus_pkg::PH_ACC && tmr.last,
                                                     state_r, done_r, state_r != ebus_pkg::PH_IDLE};
                    ebus_pkg::OFF_CMD:    dat_nxt = {29'h000_0000, we_r, cs_r};
                    ebus_pkg::OFF_ADDR:   dat_nxt = {16'h0000, addr_r};
                    ebus_pkg::OFF_WDATA:  dat_nxt = {16'h0000, wdata_r};
                    ebus_pkg::OFF_RDATA:  dat_nxt = {16'h0000, rdata_r};
                    default:              dat_nxt = 32'h0000_0000;
                endcase
            end
        end
        drive_nxt = ctrl_r[ebus_pkg::F_DRIVE+:2];
        edge_nxt  = (drive_nxt == ebus_pkg::DRV_STRONG) ? ctrl_r[ebus_pkg::F_EDGE+:2] : ebus_pkg::EDGE_SHARP;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timing_r    <= '{default: ebus_pkg::TIMING_RST};
            ctrl_r      <= ebus_pkg::CTRL_RST;
            addr_r      <= 16'h0000;
            wdata_r     <= 16'h0000;
            done_r      <= 1'b0;
            wb_ack_o    <= 1'b0;
            wb_dat_o    <= 32'h0000_0000;
            drive_sel_o <= ebus_pkg::DRV_STRONG;
            edge_sel_o  <= ebus_pkg::EDGE_SHARP;
            reference_clock_out_en_o <= 1'b0;
        end else begin
            timing_r    <= timing_nxt;
            ctrl_r      <= ctrl_nxt;
            addr_r      <= addr_nxt;
            wdata_r     <= wdata_nxt;
            done_r      <= done_nxt;
            wb_ack_o    <= ack_nxt;
            wb_dat_o    <= dat_nxt;
            drive_sel_o <= drive_nxt;
            edge_sel_o  <= edge_nxt;
            reference_clock_out_en_o <= ctrl_nxt[ebus_pkg::F_CLK_EN];
        end
    end

    // The reference clock is the system clock, gated by its enable.
    assign ref_clk_o = clk_i & reference_clock_out_en_o;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence acc_enter_s;
        state_r != ebus_pkg::PH_ACC ##1 state_r == ebus_pkg::PH_ACC;
    endsequence
    sequence ready_miss_s;
        state_r == ebus_pkg::PH_ACC && tmr.last && cfg_r[ebus_pkg::F_RDY_EN] && !rdy_act;
    endsequence

    phase_order_a: assert property (state_r == ebus_pkg::PH_CMD |=>
        state_r inside {ebus_pkg::PH_CMD, ebus_pkg::PH_WSET, ebus_pkg::PH_ACC})
        else $error("phase left out of order");
    cfg_latch_a: assert property (start |=> cfg_r == $past(timing_r[wb_dat_i[1:0]]))
        else $error("cycle timing not taken from its chip select");
    addr_len_a: assert property (ld && state_nxt == ebus_pkg::PH_ADDR |-> ld_len inside {[2:5]})
        else $error("address setup length out of range");
    strobe_late_a: assert property ($fell(rd_n_o) || $fell(wr_n_o) |->
        state_r == ebus_pkg::PH_ACC && $past(state_r) != ebus_pkg::PH_IDLE)
        else $error("strobe asserted outside access");
    acc_min_a: assert property (acc_enter_s |-> state_r == ebus_pkg::PH_ACC [*2])
        else $error("access shorter than two cycles");
    ready_wait_a: assert property (ready_miss_s |=> state_r == ebus_pkg::PH_ACC && !rd_n_o == !we_r)
        else $error("ready inactive did not insert a waitstate");
    ready_end_a: assert property (acc_end |=> state_r != ebus_pkg::PH_ACC ##1 rd_n_o && wr_n_o)
        else $error("ready active did not end access");
    hold_end_a: assert property (state_r == ebus_pkg::PH_HOLD && tmr.last |=>
        state_r == ebus_pkg::PH_IDLE && cs_n_o == 4'hF)
        else $error("hold phase did not end the cycle");
    gap_a: assert property (ld |-> ld_len >= ebus_pkg::GAP_CYC)
        else $error("phase shorter than the transition gap");
    edge_a: assert property (drive_sel_o != ebus_pkg::DRV_STRONG |-> edge_sel_o == ebus_pkg::EDGE_SHARP)
        else $error("edge select outside strong drive");
endmodule

// ===== ebus_pkg.sv
// Shared constants and types of the external bus phase sequencer.
package ebus_pkg;

    // ------------------------------------------------------------------
    // Clock and bus speed limit
    // ------------------------------------------------------------------
    localparam int SYS_CLK_KHZ   = 100_000;
    localparam int MAX_BUS_KHZ   = 80_000;
    localparam int MIN_GAP_PS    = 12_500;
    localparam int CLK_PERIOD_PS = 1_000_000_000 / SYS_CLK_KHZ;
    // Least cycles between two pin transitions, rounded up.
    localparam logic [5:0] GAP_CYC = (SYS_CLK_KHZ > MAX_BUS_KHZ)
        ? 6'((MIN_GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) : 6'h01;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_TIMING = 8'h00;
    localparam logic [7:0] OFF_CTRL   = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_CMD    = 8'h18;
    localparam logic [7:0] OFF_ADDR   = 8'h1C;
    localparam logic [7:0] OFF_WDATA  = 8'h20;
    localparam logic [7:0] OFF_RDATA  = 8'h24;

    // ------------------------------------------------------------------
    // Chip-select timing control fields and reset values
    // ------------------------------------------------------------------
    localparam int F_AS_LONG   = 0;
    localparam int F_AS_EXT    = 1;
    localparam int F_CMD_DLY   = 3;
    localparam int F_WSETUP    = 5;
    localparam int F_ACCESS    = 6;
    localparam int F_HOLD      = 11;
    localparam int F_RDY_EN    = 13;
    localparam int F_RDY_POL   = 14;
    localparam int F_RDY_ASYNC = 15;
    localparam logic [15:0] TIMING_RST = 16'h0000;

    // Control, command and status fields.
    localparam int F_DRIVE  = 0;
    localparam int F_EDGE   = 2;
    localparam int F_CLK_EN = 4;
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam int F_CMD_CS = 0;
    localparam int F_CMD_WE = 2;
    localparam int F_DONE   = 1;

    // Pad drive and edge codes.
    localparam logic [1:0] DRV_STRONG  = 2'h0;
    localparam logic [1:0] DRV_MEDIUM  = 2'h1;
    localparam logic [1:0] DRV_WEAK    = 2'h2;
    localparam logic [1:0] EDGE_SHARP  = 2'h0;
    localparam logic [1:0] EDGE_MEDIUM = 2'h1;
    localparam logic [1:0] EDGE_SLOW   = 2'h2;

    // Bus cycle phases.
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_ADDR = 3'b001,
        PH_CMD  = 3'b010,
        PH_WSET = 3'b011,
        PH_ACC  = 3'b100,
        PH_HOLD = 3'b101
    } phase_t;

endpackage

// ===== phase_if.sv
// Link between the phase sequencer and its phase length timer.
interface phase_if;
    logic       load;
    logic [5:0] len;
    logic       last;
    modport ctrl  (output load, output len, input last);
    modport timer (input load, input len, output last);
endinterface

// ===== phase_timer.sv
// Down counter that times the length of one bus cycle phase.
module phase_timer (
    input  wire logic clk_i,
    input  wire logic rst_i,
    phase_if.timer    t
);
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;

    // Load the phase length, then count down and park at one.
    always_comb begin
        cnt_nxt = cnt_r;
        if (t.load) begin
            cnt_nxt = t.len;
        end else if (cnt_r > 6'h01) begin
            cnt_nxt = cnt_r - 6'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= 6'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // The last cycle of a phase is the one where the count is down to one.
    assign t.last = (cnt_r <= 6'h01);

    count_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        t.load && t.len >= 6'h02 |=> !t.last)
        else $error("phase ended before its programmed length");
endmodule

// ===== ext_mem_model.sv
// Behavioural external memory with a programmable ready delay and polarity.
module ext_mem_model (
    input  wire logic        clk_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [15:0] dout_i,
    input  wire logic [3:0]  dly_i,
    input  wire logic        act_low_i,
    output logic      [15:0] din_o,
    output logic             ready_o,
    output logic      [15:0] wq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0]  cnt_r  = 4'h0;
    logic [15:0] last_r = 16'h0000;
    logic        strb;
    // Ready turns active after the set delay and drops as the strobe rises.
    assign strb    = !rd_n_i || !wr_n_i;
    assign ready_o = act_low_i ^ (strb && cnt_r >= dly_i);
    // Read data is valid only under the read strobe and toggles otherwise.
    assign din_o   = !rd_n_i ? addr_i ^ 16'hA5A5 : ~last_r;
    // Count strobe cycles, keep the last bus value and capture writes.
    always @(posedge clk_i) begin
        cnt_r  <= strb ? cnt_r + 4'h1 : 4'h0;
        last_r <= din_o;
        if (!wr_n_i) wq_o <= dout_i;
    end
endmodule

// ===== test_ext_bus_cycle_phase_timing.sv
// Self-checking bench of the external bus phase sequencer.
module test_ext_bus_cycle_phase_timing;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_i, cyc, stb, we, ack, ready, doe, rd_n, wr_n, clken, refclk, actl, m_we;
    logic [7:0]  adr;
    logic [31:0] dat, dat_o, q;
    logic [15:0] din, addr, dout, wq;
    logic [3:0]  cs_n, dly;
    logic [1:0]  drv, edg, m_cs;
    int bad_count, cmp_count, m_all, m_pre, m_stb, m_doe, m_oth;

    ebus_phase_seq u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .ready_i(ready),
        .ext_din_i(din), .ext_addr_o(addr), .ext_dout_o(dout), .ext_doe_o(doe), .cs_n_o(cs_n), .rd_n_o(rd_n),
        .wr_n_o(wr_n), .drive_sel_o(drv), .edge_sel_o(edg), .reference_clock_out_en_o(clken), .ref_clk_o(refclk));
    ext_mem_model u_mem (.clk_i(clk_i), .rd_n_i(rd_n), .wr_n_i(wr_n), .addr_i(addr), .dout_i(dout),
        .dly_i(dly), .act_low_i(actl), .din_o(din), .ready_o(ready), .wq_o(wq));

    // Clock of 10 ns period.
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Tally the shape of every bus cycle between clock edges.
    always @(negedge clk_i) begin
        if (cs_n !== 4'hF) begin
            m_all++;
            if (m_we ? !wr_n : !rd_n) m_stb++;
            else if (m_stb == 0) m_pre++;
            if ((m_we ? !rd_n : !wr_n) || cs_n !== ~(4'h1 << m_cs)) m_oth++;
            if (doe) m_doe++;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic Wishbone cycle; the request stands until ack is sampled high at a rising edge.
    // Read data is taken at that same edge, then the request is released and ack must drop.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        r = dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk_i);
        chk({31'h0, ack}, 32'h0);
    endtask

    // Start a bus cycle and judge its phase lengths in clock cycles.
    task automatic bus(input logic [1:0] c, input logic w, input int pre, lo, hi, hold, nd);
        int n;
        m_all = 0; m_pre = 0; m_stb = 0; m_doe = 0; m_oth = 0; m_we = w; m_cs = c;
        wb(1'b1, ebus_pkg::OFF_CMD, {29'h0, w, c}, q);
        n = 0;
        while (n < 300 && !(m_all > 0 && cs_n === 4'hF)) begin
            @(negedge clk_i);
            n++;
        end
        chk({31'h0, n >= 300}, 32'h0);
        chk(32'(m_pre), 32'(pre));
        chk({31'h0, m_stb >= lo && m_stb <= hi}, 32'h1);
        chk(32'(m_all), 32'(m_pre + m_stb + hold));
        chk(32'(m_doe), 32'(nd));
        chk(32'(m_oth), 32'h0);
    endtask

    task automatic t_reset();
        chk({26'h0, cs_n, rd_n, wr_n}, 32'h0000_003F);
        chk({27'h0, drv, edg, clken}, 32'h0);
        chk({31'h0, refclk}, 32'h0);
        wb(1'b0, ebus_pkg::OFF_TIMING, 32'h0, q);
        chk(q, 32'h0);
        wb(1'b0, 8'h40, 32'h0, q);
        chk(q, 32'h0);
    endtask

    task automatic t_read();
        wb(1'b1, ebus_pkg::OFF_ADDR, 32'h0000_1234, q);
        bus(2'h0, 1'b0, 2, 2, 2, 0, 0);
        wb(1'b0, ebus_pkg::OFF_RDATA, 32'h0, q);
        chk(q, 32'h0000_B791);
        wb(1'b0, ebus_pkg::OFF_STATUS, 32'h0, q);
        chk(q & 32'h3, 32'h2);
        wb(1'b1, ebus_pkg::OFF_STATUS, 32'h2, q);
        wb(1'b0, ebus_pkg::OFF_STATUS, 32'h0, q);
        chk(q & 32'h3, 32'h0);
    endtask

    task automatic t_write();
        wb(1'b1, 8'h04, 32'h0000_08EB, q);
        wb(1'b1, ebus_pkg::OFF_WDATA, 32'h0000_C3C3, q);
        bus(2'h1, 1'b1, 7, 4, 4, 2, 8);
        chk({16'h0, wq}, 32'h0000_C3C3);
        bus(2'h1, 1'b1, 6, 4, 4, 2, 8);
        wb(1'b0, ebus_pkg::OFF_CMD, 32'h0, q);
        chk(q, 32'h0000_0005);
    endtask

    task automatic t_ready();
        dly <= 4'h3;
        wb(1'b1, 8'h08, 32'h0000_2000, q);
        bus(2'h2, 1'b0, 2, 4, 4, 0, 0);
        dly <= 4'h1;
        actl <= 1'b1;
        wb(1'b1, 8'h0C, 32'h0000_E000, q);
        bus(2'h3, 1'b0, 2, 3, 6, 0, 0);
    endtask

    task automatic t_pads();
        for (int d = 0; d < 3; d++) begin
            for (int e = 0; e < 3; e++) begin
                wb(1'b1, ebus_pkg::OFF_CTRL, 32'(16 + e * 4 + d), q);
                repeat (2) @(negedge clk_i);
                chk({30'h0, drv}, 32'(d));
                chk({30'h0, edg}, d == 0 ? 32'(e) : 32'h0);
                chk({31'h0, refclk}, 32'h0);
                @(posedge clk_i);
                #1 chk({31'h0, refclk}, 32'h1);
            end
        end
    endtask

    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Watchdog far beyond the few hundred cycles the tests need.
    initial begin
        #200000;
        bad_count++;
        close_out();
    end

    initial begin
        rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; dat = 32'h0;
        dly = 4'h0; actl = 1'b0; m_we = 1'b0; m_cs = 2'h0; bad_count = 0; cmp_count = 0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        t_reset();
        t_read();
        t_write();
        t_ready();
        t_pads();
        close_out();
    end
endmodule
